/* File: level_gain_pkg.sv */
// constants, register map and carrier types for the audio level and gain control block
// Operation
// - bit 7 of each channel level control selects auto (1) or manual (0) gain.
// - manual mode applies the six-bit digital gain in bits 5:0.
// - auto mode uses bits 6:0 of level control as minimum gain.
// - auto mode never raises amplifier gain above the shared upper limit bits 6:0.
// - high target holds integer dB in bits 6:1 and half dB in bit 0.
// - low target holds integer dB in bits 6:1 and half dB in bit 0.
// - noise floor in the same format classifies input as noise in auto mode.
// - per-channel read-only byte shows auto gain, or manual volume.
// - peak tick period is formed from low and high configuration bytes.
// - auto mode raises gain at the configured increase speed.
// - total increase within one peak tick period is capped by a seven-bit limit.
// - auto mode lowers gain at decrease speed, or noise speed when noise.
// - decrease per peak tick period is capped, with a separate noise cap.
// - after each auto gain change, mask up to a four-bit count of samples.
// - config bits: analog en, detector filter, analog filter, tick clear, detector max.
// - software reads the applied amplifier gain per channel in auto analog mode.
// - manual amplifier value readable in bits 6:0; bit 7 reads and writes mute.
// - fix register bit 7 forces amplifier gain to its bits 6:0.
// - channel swap bit 0 exchanges left and right amplifier assignment.
// - filter bypass bit 5 set bypasses level control; clear keeps it active.
package level_gain_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int GAIN_W = 7;

  localparam logic [ADDR_W-1:0] ADDR_BYPASS = 12'hB40;
  localparam logic [ADDR_W-1:0] ADDR_LVL_L = 12'hB41;
  localparam logic [ADDR_W-1:0] ADDR_LVL_R = 12'hB42;
  localparam logic [ADDR_W-1:0] ADDR_UPPER = 12'hB43;
  localparam logic [ADDR_W-1:0] ADDR_THH = 12'hB44;
  localparam logic [ADDR_W-1:0] ADDR_THL = 12'hB46;
  localparam logic [ADDR_W-1:0] ADDR_THN = 12'hB48;
  localparam logic [ADDR_W-1:0] ADDR_RB_L = 12'hB4D;
  localparam logic [ADDR_W-1:0] ADDR_RB_R = 12'hB4E;
  localparam logic [ADDR_W-1:0] ADDR_TICK_LO = 12'hB50;
  localparam logic [ADDR_W-1:0] ADDR_TICK_HI = 12'hB51;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 12'hB54;
  localparam logic [ADDR_W-1:0] ADDR_COEF = 12'hB55;
  localparam logic [ADDR_W-1:0] ADDR_DMASK = 12'hB56;
  localparam logic [ADDR_W-1:0] ADDR_INC_SPD = 12'hB57;
  localparam logic [ADDR_W-1:0] ADDR_INC_MAX = 12'hB58;
  localparam logic [ADDR_W-1:0] ADDR_DEC_SPD = 12'hB59;
  localparam logic [ADDR_W-1:0] ADDR_DEC_MAX = 12'hB5A;
  localparam logic [ADDR_W-1:0] ADDR_NOI_SPD = 12'hB5B;
  localparam logic [ADDR_W-1:0] ADDR_NOI_MAX = 12'hB5C;
  localparam logic [ADDR_W-1:0] ADDR_AMP_L = 12'hB5E;
  localparam logic [ADDR_W-1:0] ADDR_AMP_R = 12'hB5F;
  localparam logic [ADDR_W-1:0] ADDR_JUDGE = 12'hB60;
  localparam logic [ADDR_W-1:0] ADDR_TGT_L = 12'hB61;
  localparam logic [ADDR_W-1:0] ADDR_VAL_L = 12'hB62;
  localparam logic [ADDR_W-1:0] ADDR_FIX = 12'hB63;
  localparam logic [ADDR_W-1:0] ADDR_SWAP = 12'hB64;
  localparam logic [ADDR_W-1:0] ADDR_TGT_R = 12'hB65;
  localparam logic [ADDR_W-1:0] ADDR_VAL_R = 12'hB66;

  // field positions
  localparam int AUTO_BIT = 7;
  localparam int BYPASS_BIT = 5;
  localparam int CFG_ANALOG_BIT = 0;
  localparam int CFG_DET_IIR_BIT = 1;
  localparam int CFG_ANA_IIR_BIT = 2;
  localparam int CFG_TICK_CLR_BIT = 3;
  localparam int CFG_DET_MAX_BIT = 4;
  localparam int FIX_EN_BIT = 7;
  localparam int MUTE_BIT = 7;
  localparam int SWAP_BIT = 0;
  localparam int MAN_GAIN_W = 6;
  localparam int MASK_W = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic analog_en;
    logic det_iir_en;
    logic ana_iir_en;
    logic tick_clr_en;
    logic det_max_en;
    logic [DATA_W-1:0] iir_coef;
  } filter_ctrl_t;

  typedef struct packed {
    logic [7:0] bypass, lvl_l, lvl_r, upper, thh, thl, thn, tick_lo, tick_hi;
    logic [7:0] cfg, coef, dmask, inc_spd, inc_max, dec_spd, dec_max, noi_spd, noi_max;
    logic [7:0] judge, tgt_l, tgt_r, fix, swap;
    logic mute_l, mute_r;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{bypass: 8'hFB, lvl_l: 8'h20, lvl_r: 8'h20, upper: 8'h33,
    thh: 8'h60, thl: 8'h40, thn: 8'h02, tick_lo: 8'h00, tick_hi: 8'h02, cfg: 8'h0A,
    coef: 8'hFA, dmask: 8'h00, inc_spd: 8'h0A, inc_max: 8'h03, dec_spd: 8'h08,
    dec_max: 8'h06, noi_spd: 8'h06, noi_max: 8'h06, judge: 8'h40, tgt_l: 8'h00,
    tgt_r: 8'h00, fix: 8'h80, swap: 8'h00, mute_l: 1'b0, mute_r: 1'b0};

  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic [DATA_W-1:0] spd_cnt;
    logic [GAIN_W-1:0] up_used;
    logic [GAIN_W-1:0] dn_used;
    logic [MASK_W-1:0] mask_cnt;
    logic [GAIN_W-1:0] amp_val;
    logic [DATA_W-1:0] judge_cnt;
  } chan_t;

  localparam chan_t CHAN_RESET = '0;
  localparam logic [15:0] TICK_RESET = 16'h0000;

endpackage : level_gain_pkg

/* File: level_gain_ctrl.sv */
// audio input level control and amplifier gain logic, both channels
`timescale 1ns/1ps
`default_nettype none
module level_gain_ctrl
  import level_gain_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire reg_req_t reg_req_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [1:0][GAIN_W-1:0] level_in,
  input wire logic level_valid_in,
  output logic [1:0][GAIN_W-1:0] digital_gain_out,
  output logic [1:0][GAIN_W-1:0] amp_gain_out,
  output logic [1:0] amp_mute_out,
  output logic [1:0] sample_mask_out,
  output logic level_bypass_out,
  output filter_ctrl_t filter_ctrl_out
);

  cfg_t cfg_reg;
  cfg_t cfg_next;
  chan_t chan_reg [2];
  chan_t chan_next [2];
  logic [15:0] tick_cnt_reg;
  logic [15:0] tick_cnt_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [1:0][GAIN_W-1:0] amp_gain_reg;
  logic [1:0][GAIN_W-1:0] amp_gain_next;
  logic [1:0][GAIN_W-1:0] dig_gain_reg;
  logic [1:0][GAIN_W-1:0] dig_gain_next;
  logic [1:0] mask_out_reg;
  logic [1:0] mask_out_next;

  logic [1:0][7:0] lvl_ctrl;
  logic [1:0][7:0] tgt;
  logic [1:0] auto_mode;
  logic [1:0][GAIN_W-1:0] amp_pre;
  logic [1:0] changed;
  logic [15:0] tick_period;
  logic tick_end;
  logic active;

  assign lvl_ctrl[0] = cfg_reg.lvl_l;
  assign lvl_ctrl[1] = cfg_reg.lvl_r;
  assign tgt[0] = cfg_reg.tgt_l;
  assign tgt[1] = cfg_reg.tgt_r;
  assign auto_mode[0] = cfg_reg.lvl_l[AUTO_BIT];
  assign auto_mode[1] = cfg_reg.lvl_r[AUTO_BIT];
  assign active = ~cfg_reg.bypass[BYPASS_BIT];
  assign tick_period = {cfg_reg.tick_hi, cfg_reg.tick_lo};

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always_comb
  begin
    cfg_next = cfg_reg;
    if (reg_req_in.wr)
    begin
      case (reg_req_in.addr)
        ADDR_BYPASS: cfg_next.bypass = reg_req_in.wdata;
        ADDR_LVL_L: cfg_next.lvl_l = reg_req_in.wdata;
        ADDR_LVL_R: cfg_next.lvl_r = reg_req_in.wdata;
        ADDR_UPPER: cfg_next.upper = reg_req_in.wdata;
        ADDR_THH: cfg_next.thh = reg_req_in.wdata;
        ADDR_THL: cfg_next.thl = reg_req_in.wdata;
        ADDR_THN: cfg_next.thn = reg_req_in.wdata;
        ADDR_TICK_LO: cfg_next.tick_lo = reg_req_in.wdata;
        ADDR_TICK_HI: cfg_next.tick_hi = reg_req_in.wdata;
        ADDR_CFG: cfg_next.cfg = reg_req_in.wdata;
        ADDR_COEF: cfg_next.coef = reg_req_in.wdata;
        ADDR_DMASK: cfg_next.dmask = reg_req_in.wdata;
        ADDR_INC_SPD: cfg_next.inc_spd = reg_req_in.wdata;
        ADDR_INC_MAX: cfg_next.inc_max = reg_req_in.wdata;
        ADDR_DEC_SPD: cfg_next.dec_spd = reg_req_in.wdata;
        ADDR_DEC_MAX: cfg_next.dec_max = reg_req_in.wdata;
        ADDR_NOI_SPD: cfg_next.noi_spd = reg_req_in.wdata;
        ADDR_NOI_MAX: cfg_next.noi_max = reg_req_in.wdata;
        ADDR_JUDGE: cfg_next.judge = reg_req_in.wdata;
        // bit 7 of a target is a status bit, writes only keep the target
        ADDR_TGT_L: cfg_next.tgt_l = {1'b0, reg_req_in.wdata[GAIN_W-1:0]};
        ADDR_TGT_R: cfg_next.tgt_r = {1'b0, reg_req_in.wdata[GAIN_W-1:0]};
        ADDR_VAL_L: cfg_next.mute_l = reg_req_in.wdata[MUTE_BIT];
        ADDR_VAL_R: cfg_next.mute_r = reg_req_in.wdata[MUTE_BIT];
        ADDR_FIX: cfg_next.fix = reg_req_in.wdata;
        ADDR_SWAP: cfg_next.swap = reg_req_in.wdata;
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cfg_reg <= CFG_RESET;
    else
      cfg_reg <= cfg_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // peak tick period, counted in system clocks

  always_comb
  begin
    tick_end = (tick_period == 16'h0000) || (tick_cnt_reg >= tick_period - 16'h0001);
    if (tick_end || (cfg_reg.cfg[CFG_TICK_CLR_BIT] && (|changed)))
      tick_cnt_next = TICK_RESET;
    else
      tick_cnt_next = tick_cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      tick_cnt_reg <= TICK_RESET;
    else
      tick_cnt_reg <= tick_cnt_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel tracking and manual amplifier ramp

  always_comb
  begin
    logic [GAIN_W-1:0] lvl;
    logic [GAIN_W-1:0] gmin;
    logic [GAIN_W-1:0] gmax;
    logic [GAIN_W-1:0] cap;
    logic [DATA_W-1:0] spd;
    logic noise;
    logic want_up;
    logic want_dn;
    logic [GAIN_W-1:0] g;
    lvl = '0;
    gmin = '0;
    gmax = '0;
    cap = '0;
    spd = '0;
    noise = 1'b0;
    want_up = 1'b0;
    want_dn = 1'b0;
    g = '0;
    changed = 2'b00;
    for (int c = 0; c < 2; c++)
    begin
      chan_next[c] = chan_reg[c];
      lvl = level_in[c];
      gmin = lvl_ctrl[c][GAIN_W-1:0];
      gmax = cfg_reg.upper[GAIN_W-1:0];
      noise = lvl < cfg_reg.thn[GAIN_W-1:0];
      want_dn = noise || (lvl > cfg_reg.thh[GAIN_W-1:0]);
      want_up = !noise && (lvl < cfg_reg.thl[GAIN_W-1:0]);
      spd = want_up ? cfg_reg.inc_spd : (noise ? cfg_reg.noi_spd : cfg_reg.dec_spd);
      cap = want_up ? cfg_reg.inc_max[GAIN_W-1:0]
        : (noise ? cfg_reg.noi_max[GAIN_W-1:0] : cfg_reg.dec_max[GAIN_W-1:0]);
      g = chan_reg[c].gain;
      if (tick_end)
      begin
        chan_next[c].up_used = '0;
        chan_next[c].dn_used = '0;
      end
      if (auto_mode[c] && active)
      begin
        // limits may move under a running gain, so clamp first; max wins if they cross
        if (g < gmin)
          g = gmin;
        if (g > gmax)
          g = gmax;
        if (level_valid_in && (chan_reg[c].mask_cnt != '0))
          chan_next[c].mask_cnt = chan_reg[c].mask_cnt - 1'b1;
        else if (level_valid_in && (want_up || want_dn))
        begin
          if (chan_reg[c].spd_cnt >= spd)
          begin
            chan_next[c].spd_cnt = '0;
            if (want_up && (g < gmax) && (chan_reg[c].up_used < cap))
            begin
              g = g + 1'b1;
              if (!tick_end)
                chan_next[c].up_used = chan_reg[c].up_used + 1'b1;
            end
            else if (want_dn && (g > gmin) && (chan_reg[c].dn_used < cap))
            begin
              g = g - 1'b1;
              if (!tick_end)
                chan_next[c].dn_used = chan_reg[c].dn_used + 1'b1;
            end
          end
          else
            chan_next[c].spd_cnt = chan_reg[c].spd_cnt + 1'b1;
        end
        else if (level_valid_in)
          chan_next[c].spd_cnt = '0;
        if (g != chan_reg[c].gain)
        begin
          changed[c] = 1'b1;
          chan_next[c].mask_cnt = cfg_reg.dmask[MASK_W-1:0];
        end
        chan_next[c].gain = g;
      end
      else
        chan_next[c].mask_cnt = '0;
      // manual amplifier ramp: one step every judge-speed plus one clocks toward target
      if (chan_reg[c].amp_val == tgt[c][GAIN_W-1:0])
        chan_next[c].judge_cnt = '0;
      else if (chan_reg[c].judge_cnt >= cfg_reg.judge)
      begin
        chan_next[c].judge_cnt = '0;
        if (chan_reg[c].amp_val < tgt[c][GAIN_W-1:0])
          chan_next[c].amp_val = chan_reg[c].amp_val + 1'b1;
        else
          chan_next[c].amp_val = chan_reg[c].amp_val - 1'b1;
      end
      else
        chan_next[c].judge_cnt = chan_reg[c].judge_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      chan_reg[0] <= CHAN_RESET;
      chan_reg[1] <= CHAN_RESET;
    end
    else
    begin
      chan_reg[0] <= chan_next[0];
      chan_reg[1] <= chan_next[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gain selection and outputs

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (cfg_reg.fix[FIX_EN_BIT])
        amp_pre[c] = cfg_reg.fix[GAIN_W-1:0];
      else if (auto_mode[c] && active && cfg_reg.cfg[CFG_ANALOG_BIT])
        amp_pre[c] = chan_reg[c].gain;
      else
        amp_pre[c] = chan_reg[c].amp_val;
      if (auto_mode[c] && active && !cfg_reg.cfg[CFG_ANALOG_BIT])
        dig_gain_next[c] = chan_reg[c].gain;
      else
        dig_gain_next[c] = {1'b0, lvl_ctrl[c][MAN_GAIN_W-1:0]};
      mask_out_next[c] = chan_reg[c].mask_cnt != '0;
    end
    if (cfg_reg.swap[SWAP_BIT])
      amp_gain_next = {amp_pre[0], amp_pre[1]};
    else
      amp_gain_next = amp_pre;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      amp_gain_reg <= '0;
      dig_gain_reg <= '0;
      mask_out_reg <= 2'b00;
    end
    else
    begin
      amp_gain_reg <= amp_gain_next;
      dig_gain_reg <= dig_gain_next;
      mask_out_reg <= mask_out_next;
    end
  end

  assign amp_gain_out = amp_gain_reg;
  assign digital_gain_out = dig_gain_reg;
  assign sample_mask_out = mask_out_reg;
  assign amp_mute_out = {cfg_reg.mute_r, cfg_reg.mute_l};
  assign level_bypass_out = cfg_reg.bypass[BYPASS_BIT];
  assign filter_ctrl_out = '{analog_en: cfg_reg.cfg[CFG_ANALOG_BIT],
    det_iir_en: cfg_reg.cfg[CFG_DET_IIR_BIT], ana_iir_en: cfg_reg.cfg[CFG_ANA_IIR_BIT],
    tick_clr_en: cfg_reg.cfg[CFG_TICK_CLR_BIT], det_max_en: cfg_reg.cfg[CFG_DET_MAX_BIT],
    iir_coef: cfg_reg.coef};

  ////////////////////////////////////////////////////////////////////////////
  // register reads, data valid in the cycle after the strobe only

  always_comb
  begin
    rdata_next = '0;
    if (reg_req_in.rd)
    begin
      case (reg_req_in.addr)
        ADDR_BYPASS: rdata_next = cfg_reg.bypass;
        ADDR_LVL_L: rdata_next = cfg_reg.lvl_l;
        ADDR_LVL_R: rdata_next = cfg_reg.lvl_r;
        ADDR_UPPER: rdata_next = cfg_reg.upper;
        ADDR_THH: rdata_next = cfg_reg.thh;
        ADDR_THL: rdata_next = cfg_reg.thl;
        ADDR_THN: rdata_next = cfg_reg.thn;
        ADDR_RB_L: rdata_next = {1'b0, auto_mode[0] ? chan_reg[0].gain
          : {1'b0, cfg_reg.lvl_l[MAN_GAIN_W-1:0]}};
        ADDR_RB_R: rdata_next = {1'b0, auto_mode[1] ? chan_reg[1].gain
          : {1'b0, cfg_reg.lvl_r[MAN_GAIN_W-1:0]}};
        ADDR_TICK_LO: rdata_next = cfg_reg.tick_lo;
        ADDR_TICK_HI: rdata_next = cfg_reg.tick_hi;
        ADDR_CFG: rdata_next = cfg_reg.cfg;
        ADDR_COEF: rdata_next = cfg_reg.coef;
        ADDR_DMASK: rdata_next = cfg_reg.dmask;
        ADDR_INC_SPD: rdata_next = cfg_reg.inc_spd;
        ADDR_INC_MAX: rdata_next = cfg_reg.inc_max;
        ADDR_DEC_SPD: rdata_next = cfg_reg.dec_spd;
        ADDR_DEC_MAX: rdata_next = cfg_reg.dec_max;
        ADDR_NOI_SPD: rdata_next = cfg_reg.noi_spd;
        ADDR_NOI_MAX: rdata_next = cfg_reg.noi_max;
        ADDR_AMP_L: rdata_next = {1'b0, amp_gain_reg[0]};
        ADDR_AMP_R: rdata_next = {1'b0, amp_gain_reg[1]};
        ADDR_JUDGE: rdata_next = cfg_reg.judge;
        ADDR_TGT_L: rdata_next = {chan_reg[0].amp_val == cfg_reg.tgt_l[GAIN_W-1:0],
          cfg_reg.tgt_l[GAIN_W-1:0]};
        ADDR_TGT_R: rdata_next = {chan_reg[1].amp_val == cfg_reg.tgt_r[GAIN_W-1:0],
          cfg_reg.tgt_r[GAIN_W-1:0]};
        ADDR_VAL_L: rdata_next = {cfg_reg.mute_l, chan_reg[0].amp_val};
        ADDR_VAL_R: rdata_next = {cfg_reg.mute_r, chan_reg[1].amp_val};
        ADDR_FIX: rdata_next = cfg_reg.fix;
        ADDR_SWAP: rdata_next = cfg_reg.swap;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata_out = rdata_reg;

endmodule : level_gain_ctrl
`default_nettype wire

/* File: level_gain_properties.sv */
// port-level property checker for the level and gain control block
`timescale 1ns/1ps
`default_nettype none
module level_gain_properties
  import level_gain_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire reg_req_t reg_req_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [1:0][GAIN_W-1:0] amp_gain_out,
  input wire logic [1:0][GAIN_W-1:0] digital_gain_out,
  input wire logic [1:0] amp_mute_out,
  input wire logic level_bypass_out,
  input wire filter_ctrl_t filter_ctrl_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  wire logic wr = reg_req_in.wr;
  wire logic rd = reg_req_in.rd;
  wire logic [ADDR_W-1:0] a = reg_req_in.addr;
  wire logic [DATA_W-1:0] wd = reg_req_in.wdata;
  // config bits listed in struct order, lsb first
  wire logic [4:0] cfg_rev = {wd[0], wd[1], wd[2], wd[3], wd[4]};
  //////////////////////////////////////////////////////////////////////////////
  property p_rd_idle;
    !$past(rd) |-> reg_rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read cycle");
  property p_unmapped;
    rd && a == 12'hB45 |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("reserved address read not zero");
  property p_bypass;
    wr && a == ADDR_BYPASS |=> level_bypass_out == $past(wd[BYPASS_BIT]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass output does not follow write");
  property p_mute_l;
    wr && a == ADDR_VAL_L |=> amp_mute_out[0] == $past(wd[MUTE_BIT]);
  endproperty
  a_mute_l: assert property (p_mute_l) else $error("left mute does not follow write");
  property p_mute_r;
    wr && a == ADDR_VAL_R |=> amp_mute_out[1] == $past(wd[MUTE_BIT]);
  endproperty
  a_mute_r: assert property (p_mute_r) else $error("right mute does not follow write");
  property p_cfg;
    wr && a == ADDR_CFG |=> {filter_ctrl_out.analog_en, filter_ctrl_out.det_iir_en, filter_ctrl_out.ana_iir_en,
      filter_ctrl_out.tick_clr_en, filter_ctrl_out.det_max_en} == $past(cfg_rev);
  endproperty
  a_cfg: assert property (p_cfg) else $error("filter enables do not follow config write");
  property p_fix;
    wr && a == ADDR_FIX && wd[FIX_EN_BIT] |-> ##2 amp_gain_out == {2{$past(wd[6:0], 2)}};
  endproperty
  a_fix: assert property (p_fix) else $error("forced amplifier gain not applied");
  property p_man_l;
    wr && a == ADDR_LVL_L && !wd[AUTO_BIT] |-> ##2 digital_gain_out[0] == {1'b0, $past(wd[5:0], 2)};
  endproperty
  a_man_l: assert property (p_man_l) else $error("left manual gain not applied");
  c_fix: cover property (wr && a == ADDR_FIX && wd[FIX_EN_BIT]);
  c_mute: cover property (amp_mute_out == 2'b11);
  c_rb: cover property (rd && a == ADDR_RB_L && !level_bypass_out);
endmodule : level_gain_properties
bind level_gain_ctrl level_gain_properties u_props (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
  .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .amp_gain_out(amp_gain_out),
  .digital_gain_out(digital_gain_out), .amp_mute_out(amp_mute_out), .level_bypass_out(level_bypass_out),
  .filter_ctrl_out(filter_ctrl_out));
`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for the level and gain control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import level_gain_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  reg_req_t req = '0;
  logic [1:0][GAIN_W-1:0] lvl = '0;
  logic lvl_vld = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [1:0][GAIN_W-1:0] dgain, again;
  logic [1:0] mute, smask;
  logic byp;
  filter_ctrl_t fctl;
  int n_fail = 0;
  int n_compared = 0;
  int seed = 32'hED0A8A84;
  logic [7:0] d;
  // register model: address to expected contents, kept up to date by every write to an address it holds
  int regm [int];
  // address and reset value of every writable register except the two targets and the two amplifier value registers
  logic [19:0] rv [21] = '{20'hB40FB, 20'hB4120, 20'hB4220, 20'hB4333, 20'hB4460, 20'hB4640, 20'hB4802,
    20'hB5000, 20'hB5102, 20'hB540A, 20'hB55FA, 20'hB5600, 20'hB570A, 20'hB5803, 20'hB5908, 20'hB5A06,
    20'hB5B06, 20'hB5C06, 20'hB6040, 20'hB6380, 20'hB6400};
  always #5 clk_sys_in = ~clk_sys_in;
  level_gain_ctrl u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .level_in(lvl), .level_valid_in(lvl_vld), .digital_gain_out(dgain), .amp_gain_out(again),
    .amp_mute_out(mute), .sample_mask_out(smask), .level_bypass_out(byp), .filter_ctrl_out(fctl));
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one idle cycle after each strobe so no signal is driven twice in a step
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    if (regm.exists(a))
      regm[a] = v;
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk_sys_in);
    req.wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wr
  task automatic chkrd(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] v;
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys_in);
    req.rd <= 1'b0;
    #1 v = rdata;
    chk(v, exp);
    @(posedge clk_sys_in);
  endtask : chkrd
  task automatic send(input int n, input logic [6:0] lv);
    repeat (n)
    begin
      lvl[0] <= lv;
      lvl_vld <= 1'b1;
      @(posedge clk_sys_in);
      lvl_vld <= 1'b0;
      @(posedge clk_sys_in);
    end
    repeat (2) @(posedge clk_sys_in);
  endtask : send
  task automatic chkg(input logic [7:0] e);
    // digital gain lags the tracked gain by one clock, so read back first
    chkrd(ADDR_RB_L, e);
    chk({1'b0, dgain[0]}, e);
  endtask : chkg
  task automatic wait_amp(input logic [13:0] e);
    int k;
    k = 0;
    while (again !== e && k < 300)
    begin
      @(posedge clk_sys_in);
      k++;
    end
    if (k == 300)
    begin
      n_fail++;
      print_verdict();
    end
  endtask : wait_amp
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk_sys_in);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    foreach (rv[i])
      regm[rv[i][19:8]] = rv[i][7:0];
    foreach (rv[i])
      chkrd(rv[i][19:8], 8'(regm[rv[i][19:8]]));
    // random data into every register listed in rv, then restore
    foreach (rv[i])
    begin
      d = 8'($random(seed));
      wr(rv[i][19:8], d);
      chkrd(rv[i][19:8], 8'(regm[rv[i][19:8]]));
      wr(rv[i][19:8], rv[i][7:0]);
    end
    wr(12'hB45, 8'h5A);
    chkrd(12'hB45, 8'h00);
    wr(ADDR_AMP_L, 8'h11);
    chkrd(ADDR_AMP_L, 8'h00);
    d = 8'($random(seed)) & 8'h7F;
    wr(ADDR_LVL_L, d);
    chkrd(ADDR_RB_L, {2'b00, d[5:0]});
    chk({1'b0, dgain[0]}, {2'b00, d[5:0]});
    // manual amplifier ramp, fastest judge speed
    wr(ADDR_FIX, 8'h00);
    wr(ADDR_JUDGE, 8'h00);
    wr(ADDR_TGT_L, 8'h15);
    wr(ADDR_TGT_R, 8'h2A);
    wait_amp({7'h2A, 7'h15});
    chkrd(ADDR_TGT_L, 8'h95);
    chkrd(ADDR_TGT_R, 8'hAA);
    chkrd(ADDR_VAL_L, 8'h15);
    wr(ADDR_VAL_L, 8'h80);
    wr(ADDR_VAL_R, 8'h80);
    chkrd(ADDR_VAL_L, 8'h95);
    chk({6'h00, mute}, 8'h03);
    wr(ADDR_VAL_L, 8'h00);
    wr(ADDR_VAL_R, 8'h00);
    wr(ADDR_SWAP, 8'h01);
    chkrd(ADDR_AMP_L, 8'h2A);
    chk({1'b0, again[1]}, 8'h15);
    wr(ADDR_SWAP, 8'h00);
    wr(ADDR_FIX, 8'hB3);
    chkrd(ADDR_AMP_R, 8'h33);
    wr(ADDR_FIX, 8'h00);
    // auto mode on left, right stays manual
    wr(ADDR_BYPASS, 8'hDB);
    wr(ADDR_UPPER, 8'h06);
    wr(ADDR_INC_SPD, 8'h02);
    wr(ADDR_INC_MAX, 8'h01);
    wr(ADDR_LVL_L, 8'h82);
    chkg(8'h02);
    chk({1'b0, dgain[1]}, 8'h20);
    send(2, 7'h10);
    chkg(8'h02);
    send(1, 7'h10);
    chkg(8'h03);
    send(3, 7'h10);
    chkg(8'h03);
    wr(ADDR_INC_SPD, 8'h00);
    wr(ADDR_INC_MAX, 8'h7F);
    send(8, 7'h10);
    chkg(8'h06);
    wr(ADDR_NOI_SPD, 8'h00);
    wr(ADDR_NOI_MAX, 8'h01);
    send(3, 7'h00);
    chkg(8'h05);
    wr(ADDR_DEC_SPD, 8'h00);
    wr(ADDR_DEC_MAX, 8'h7F);
    send(8, 7'h70);
    chkg(8'h02);
    // masked samples after a change must not move the gain
    wr(ADDR_DMASK, 8'h02);
    send(1, 7'h10);
    chk({7'h00, smask[0]}, 8'h01);
    send(2, 7'h10);
    chkg(8'h03);
    chk({7'h00, smask[0]}, 8'h00);
    send(1, 7'h10);
    chkg(8'h04);
    // analog mode routes the tracked gain to the amplifier, digital gain falls back to manual
    wr(ADDR_CFG, 8'h0B);
    chkrd(ADDR_AMP_L, 8'h04);
    chk({1'b0, dgain[0]}, 8'h02);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
